//--- pkg/nvr_pkg.sv
package nvr_pkg;

  // Array geometry
  localparam int NVR_ADDR_W = 9;
  localparam int NVR_DEPTH = 512;

  // Memory opcodes, low and high half of the array
  localparam logic [7:0] OP_WRITE_LOW = 8'h02;
  localparam logic [7:0] OP_WRITE_HIGH = 8'h0A;
  localparam logic [7:0] OP_READ_LOW = 8'h03;
  localparam logic [7:0] OP_READ_HIGH = 8'h0B;
  localparam int OP_ADDR_MSB_POS = 3;
  localparam logic [7:0] OP_ADDR_MSB_MASK = 8'h08;

  // Default codes for the commands without an address (arbitrary, overridable)
  localparam logic [7:0] OP_SET_PERMIT_DEF = 8'h06;
  localparam logic [7:0] OP_CLEAR_PERMIT_DEF = 8'h04;
  localparam logic [7:0] OP_STATUS_READ_DEF = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE_DEF = 8'h01;

  // Status byte layout and reset
  localparam int STAT_LATCH_POS = 1;
  localparam int STAT_PROT_LOW_POS = 2;
  localparam int STAT_PROT_HIGH_POS = 3;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // Serial framing
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] SYNC_RESET = 3'h4;

  typedef struct packed {
    logic [3:0] zero_hi;
    logic protect_select_high;
    logic protect_select_low;
    logic write_permit_latch;
    logic zero_lo;
  } nvr_status_type;

  typedef struct packed {
    logic set_permit;
    logic clear_permit;
    logic status_read;
    logic status_write;
    logic mem_read;
    logic mem_write;
    logic addr_msb;
  } nvr_cmd_type;

  typedef enum logic [6:0] {
    ST_OPCODE = 7'h01,
    ST_ADDR = 7'h02,
    ST_WR_DATA = 7'h04,
    ST_RD_DATA = 7'h08,
    ST_STAT_WR = 7'h10,
    ST_STAT_RD = 7'h20,
    ST_IGNORE = 7'h40
  } nvr_state_type;

endpackage : nvr_pkg

//--- verif/nvr_core_assertions.sv
`timescale 1ns/1ps

module nvr_core_assertions (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic cs_n_pin,
  input wire logic sck_pin,
  input wire logic si_pin,
  input wire logic so_out,
  input wire logic so_oe,
  input wire nvr_pkg::nvr_status_type device_status_flags
);
  // Chip select idle long enough to settle
  sequence s_cs_idle;
    cs_n_pin [*6];
  endsequence

  a_bit0_zero: assert property (@(posedge ref_clk) disable iff (srst)
    device_status_flags.zero_lo == 1'b0) else $error("status bit 0 set");
  a_high_zero: assert property (@(posedge ref_clk) disable iff (srst)
    device_status_flags.zero_hi == 4'h0) else $error("status bits 7:4 set");
  a_reset_clear: assert property (@(posedge ref_clk)
    srst |=> device_status_flags == 8'h00 && !so_oe) else $error("reset not cleared");
  a_idle_stable: assert property (@(posedge ref_clk) disable iff (srst)
    s_cs_idle |=> $stable(device_status_flags)) else $error("status moved while idle");
  a_protect_latch: assert property (@(posedge ref_clk) disable iff (srst)
    $changed(device_status_flags[3:2]) |-> $past(device_status_flags.write_permit_latch))
    else $error("protect written without latch");
  a_latch_in_frame: assert property (@(posedge ref_clk) disable iff (srst)
    $rose(device_status_flags.write_permit_latch) |-> $past(cs_n_pin, 3) == 1'b0)
    else $error("latch set outside frame");
  a_oe_in_frame: assert property (@(posedge ref_clk) disable iff (srst)
    $rose(so_oe) |-> !cs_n_pin ##1 so_oe) else $error("output enabled outside frame");
  a_oe_idle_off: assert property (@(posedge ref_clk) disable iff (srst)
    s_cs_idle |-> !so_oe) else $error("output still enabled");
endmodule : nvr_core_assertions

bind nvr_core nvr_core_assertions u_chk (.ref_clk(ref_clk), .srst(srst),
  .cs_n_pin(cs_n_pin), .sck_pin(sck_pin), .si_pin(si_pin), .so_out(so_out),
  .so_oe(so_oe), .device_status_flags(device_status_flags));

//--- verif/nvr_host_model.sv
`timescale 1ns/1ps

module nvr_host_model (
  input wire logic ref_clk,
  input wire logic so_out,
  output logic cs_n_pin,
  output logic sck_pin,
  output logic si_pin
);
  // Idle bus levels
  initial begin
    cs_n_pin = 1'b1;
    sck_pin = 1'b0;
    si_pin = 1'b0;
  end

  // Wait on falling edges
  task automatic gap(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : gap

  task automatic xfer_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si_pin = tx[i];
      gap(6);
      rx[i] = so_out;
      sck_pin = 1'b1;
      gap(6);
      sck_pin = 1'b0;
    end
  endtask : xfer_byte

  task automatic frame(input logic [7:0] b0, b1, b2, input int n, output logic [7:0] rx);
    logic [7:0] bytes [3];
    bytes = '{b0, b1, b2};
    cs_n_pin = 1'b0;
    gap(6);
    for (int k = 0; k < n; k++) begin
      xfer_byte(bytes[k], rx);
    end
    gap(2);
    cs_n_pin = 1'b1;
    si_pin = ~si_pin; // Released line shows no stale level
    gap(8);
  endtask : frame
endmodule : nvr_host_model

//--- verif/tb.sv
`timescale 1ns/1ps

module tb;
  logic ref_clk;
  logic srst;
  logic cs_n_pin, sck_pin, si_pin, so_out, so_oe;
  nvr_pkg::nvr_status_type device_status_flags;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  logic [7:0] rx;

  // Clock source
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  nvr_core u_dut (.ref_clk(ref_clk), .srst(srst), .cs_n_pin(cs_n_pin), .sck_pin(sck_pin),
    .si_pin(si_pin), .so_out(so_out), .so_oe(so_oe),
    .device_status_flags(device_status_flags));

  nvr_host_model u_host (.ref_clk(ref_clk), .so_out(so_out), .cs_n_pin(cs_n_pin),
    .sck_pin(sck_pin), .si_pin(si_pin));

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask : check

  task automatic report_and_stop();
    if (num_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic cmd(input logic [7:0] b0, b1, b2, input int n);
    u_host.frame(b0, b1, b2, n, rx);
  endtask : cmd

  // Hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      $display("MISMATCH %0t timeout", $time);
      report_and_stop();
    end
  end

  // Reset and enable latch readback
  task automatic t_permit();
    check(device_status_flags, 8'h00);
    check({7'h00, so_oe}, 8'h00);
    cmd(8'h06, 8'h00, 8'h00, 1);
    check(device_status_flags, 8'h02);
    cmd(8'h05, 8'h00, 8'h00, 2);
    check(rx, 8'h02);
  endtask : t_permit

  // Lower half write clears latch, then refused
  task automatic t_low_write();
    cmd(8'h02, 8'h10, 8'h11, 3);
    check(device_status_flags, 8'h00);
    cmd(8'h02, 8'h10, 8'h22, 3);
    cmd(8'h03, 8'h10, 8'h00, 3);
    check(rx, 8'h11);
  endtask : t_low_write

  // Upper half write keeps latch
  task automatic t_high_write();
    cmd(8'h06, 8'h00, 8'h00, 1);
    cmd(8'h0A, 8'h10, 8'h33, 3);
    check(device_status_flags, 8'h02);
    cmd(8'h0A, 8'h10, 8'h44, 3);
    cmd(8'h0B, 8'h10, 8'h00, 3);
    check(rx, 8'h44);
    cmd(8'h03, 8'h10, 8'h00, 3);
    check(rx, 8'h11);
    cmd(8'h04, 8'h00, 8'h00, 1);
    check(device_status_flags, 8'h00);
  endtask : t_high_write

  // Status write masks fixed bits and latch
  task automatic t_status();
    cmd(8'h06, 8'h00, 8'h00, 1);
    cmd(8'h01, 8'hFF, 8'h00, 2);
    check(device_status_flags, 8'h0C);
    cmd(8'h06, 8'h00, 8'h00, 1);
    cmd(8'h0A, 8'h20, 8'h55, 3);
    cmd(8'h01, 8'h04, 8'h00, 2);
    check(device_status_flags, 8'h04);
    cmd(8'h06, 8'h00, 8'h00, 1);
    cmd(8'h04, 8'h00, 8'h00, 1);
    cmd(8'h01, 8'h0A, 8'h00, 2);
    check(device_status_flags, 8'h04);
    cmd(8'h05, 8'h00, 8'h00, 2);
    check(rx, 8'h04);
  endtask : t_status

  // Main sequence
  initial begin
    srst = 1'b1;
    repeat (12) @(negedge ref_clk);
    srst = 1'b0;
    @(negedge ref_clk);
    t_permit();
    t_low_write();
    t_high_write();
    t_status();
    report_and_stop();
  end
endmodule : tb

//--- verilog/nvr_core.sv
`timescale 1ns/1ps

module nvr_core #(
  parameter logic [7:0] OP_SET_PERMIT = nvr_pkg::OP_SET_PERMIT_DEF,
  parameter logic [7:0] OP_CLEAR_PERMIT = nvr_pkg::OP_CLEAR_PERMIT_DEF,
  parameter logic [7:0] OP_STATUS_READ = nvr_pkg::OP_STATUS_READ_DEF,
  parameter logic [7:0] OP_STATUS_WRITE = nvr_pkg::OP_STATUS_WRITE_DEF,
  parameter int DEPTH = nvr_pkg::NVR_DEPTH
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic cs_n_pin,
  input wire logic sck_pin,
  input wire logic si_pin,
  output logic so_out,
  output logic so_oe,
  output nvr_pkg::nvr_status_type device_status_flags
);

  localparam int AW = nvr_pkg::NVR_ADDR_W;

  logic [2:0] pin_level;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;
  logic cs_n_lvl;
  logic sck_rise;
  logic sck_fall;
  logic si_lvl;
  logic cs_rise;
  logic [7:0] shift_in;
  logic [7:0] rx_byte;
  logic [2:0] bit_cnt;
  logic byte_done;
  nvr_pkg::nvr_state_type state;
  nvr_pkg::nvr_cmd_type cmd;
  logic op_upper;
  logic op_read;
  logic [AW-1:0] addr;
  logic [AW-1:0] start_addr;
  logic [7:0] out_byte;
  logic [7:0] load_byte;
  logic load_en;
  logic pend_clear;
  logic mem_wr_en;
  logic permit_q;
  logic prot_low_q;
  logic prot_high_q;
  logic [7:0] mem [0:DEPTH-1];

  // Wrapping address increment
  function automatic logic [AW-1:0] nvr_next_addr(input logic [AW-1:0] a);
    nvr_next_addr = a + {{(AW-1){1'b0}}, 1'b1};
  endfunction : nvr_next_addr

  // Pin synchronisers: chip select idles high
  nvr_sync #(
    .WIDTH(3),
    .RST_VAL(nvr_pkg::SYNC_RESET)
  ) u_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .async_in({cs_n_pin, sck_pin, si_pin}),
    .level(pin_level),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  assign cs_n_lvl = pin_level[2];
  assign cs_rise = pin_rise[2];
  assign sck_rise = pin_rise[1] & ~cs_n_lvl;
  assign sck_fall = pin_fall[1] & ~cs_n_lvl;
  assign si_lvl = pin_level[0];

  assign rx_byte = {shift_in[6:0], si_lvl};
  assign byte_done = sck_rise && (bit_cnt == nvr_pkg::BIT_LAST);

  // Opcode decoder sees the byte as it completes
  nvr_opdec #(
    .OP_SET_PERMIT(OP_SET_PERMIT),
    .OP_CLEAR_PERMIT(OP_CLEAR_PERMIT),
    .OP_STATUS_READ(OP_STATUS_READ),
    .OP_STATUS_WRITE(OP_STATUS_WRITE)
  ) u_opdec (
    .opcode(rx_byte),
    .cmd(cmd)
  );

  assign start_addr = {op_upper, rx_byte};

  // Bit counter and input shifter
  always_ff @(posedge ref_clk) begin
    if (srst || cs_n_lvl) begin
      shift_in <= 8'h00;
      bit_cnt <= nvr_pkg::BIT_FIRST;
    end else if (sck_rise) begin
      shift_in <= rx_byte;
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  // Command sequencer, one byte per step
  always_ff @(posedge ref_clk) begin
    if (srst || cs_n_lvl) begin
      state <= nvr_pkg::ST_OPCODE;
    end else if (byte_done) begin
      unique case (state)
        nvr_pkg::ST_OPCODE: begin
          if (cmd.mem_read || cmd.mem_write) begin
            state <= nvr_pkg::ST_ADDR;
          end else if (cmd.status_write) begin
            state <= nvr_pkg::ST_STAT_WR;
          end else if (cmd.status_read) begin
            state <= nvr_pkg::ST_STAT_RD;
          end else begin
            state <= nvr_pkg::ST_IGNORE;
          end
        end
        nvr_pkg::ST_ADDR: begin
          state <= op_read ? nvr_pkg::ST_RD_DATA : nvr_pkg::ST_WR_DATA;
        end
        nvr_pkg::ST_STAT_WR: begin
          state <= nvr_pkg::ST_IGNORE;
        end
        nvr_pkg::ST_WR_DATA, nvr_pkg::ST_RD_DATA, nvr_pkg::ST_STAT_RD,
        nvr_pkg::ST_IGNORE: begin
          state <= state;
        end
        default: begin
          state <= nvr_pkg::ST_IGNORE;
        end
      endcase
    end
  end

  // Opcode attributes held for the frame
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      op_upper <= 1'b0;
      op_read <= 1'b0;
    end else if (byte_done && state == nvr_pkg::ST_OPCODE) begin
      op_upper <= cmd.addr_msb;
      op_read <= cmd.mem_read;
    end
  end

  // Address pointer with wrap across the whole array
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      addr <= '0;
    end else if (byte_done) begin
      if (state == nvr_pkg::ST_ADDR) begin
        addr <= op_read ? nvr_next_addr(start_addr) : start_addr;
      end else if (state == nvr_pkg::ST_WR_DATA || state == nvr_pkg::ST_RD_DATA) begin
        addr <= nvr_next_addr(addr);
      end
    end
  end

  assign mem_wr_en = byte_done && (state == nvr_pkg::ST_WR_DATA)
                     && device_status_flags.write_permit_latch;

  // Array store, contents kept across reset
  always_ff @(posedge ref_clk) begin
    if (mem_wr_en) begin
      mem[addr] <= rx_byte;
    end
  end

  // Next byte to present on the serial output
  always_comb begin
    load_en = 1'b0;
    load_byte = 8'h00;
    if (byte_done) begin
      if (state == nvr_pkg::ST_OPCODE && cmd.status_read) begin
        load_en = 1'b1;
        load_byte = device_status_flags;
      end else if (state == nvr_pkg::ST_STAT_RD) begin
        load_en = 1'b1;
        load_byte = device_status_flags;
      end else if (state == nvr_pkg::ST_ADDR && op_read) begin
        load_en = 1'b1;
        load_byte = mem[start_addr];
      end else if (state == nvr_pkg::ST_RD_DATA) begin
        load_en = 1'b1;
        load_byte = mem[addr];
      end
    end
  end

  // Serial output: msb at load, next bit on each falling clock
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      out_byte <= 8'h00;
      so_out <= 1'b0;
      so_oe <= 1'b0;
    end else if (cs_n_lvl) begin
      so_out <= 1'b0;
      so_oe <= 1'b0;
    end else if (load_en) begin
      out_byte <= load_byte;
      so_out <= load_byte[7];
      so_oe <= 1'b1;
    end else if (sck_fall && (state == nvr_pkg::ST_RD_DATA || state == nvr_pkg::ST_STAT_RD)) begin
      so_out <= out_byte[nvr_pkg::BIT_LAST - bit_cnt];
    end
  end

  // Completed status or lower-half write pending latch clear at frame end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pend_clear <= 1'b0;
    end else if (byte_done && state == nvr_pkg::ST_STAT_WR
                 && device_status_flags.write_permit_latch) begin
      pend_clear <= 1'b1;
    end else if (mem_wr_en && !op_upper) begin
      pend_clear <= 1'b1;
    end else if (cs_rise) begin
      pend_clear <= 1'b0;
    end
  end

  // Write permit latch
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      permit_q <= nvr_pkg::STATUS_RESET[nvr_pkg::STAT_LATCH_POS];
    end else if (byte_done && state == nvr_pkg::ST_OPCODE && cmd.set_permit) begin
      permit_q <= 1'b1;
    end else if (byte_done && state == nvr_pkg::ST_OPCODE && cmd.clear_permit) begin
      permit_q <= 1'b0;
    end else if (cs_rise && pend_clear) begin
      permit_q <= 1'b0;
    end
  end

  // Protect selects, written by an enabled status write
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prot_low_q <= nvr_pkg::STATUS_RESET[nvr_pkg::STAT_PROT_LOW_POS];
      prot_high_q <= nvr_pkg::STATUS_RESET[nvr_pkg::STAT_PROT_HIGH_POS];
    end else if (byte_done && state == nvr_pkg::ST_STAT_WR
                 && device_status_flags.write_permit_latch) begin
      prot_low_q <= rx_byte[nvr_pkg::STAT_PROT_LOW_POS];
      prot_high_q <= rx_byte[nvr_pkg::STAT_PROT_HIGH_POS];
    end
  end

  // Status byte from its flops, one driver for the whole output
  // bit 0 zero
  assign device_status_flags = {4'h0, prot_high_q, prot_low_q, permit_q, 1'b0};

endmodule : nvr_core

//--- verilog/nvr_opdec.sv
`timescale 1ns/1ps

module nvr_opdec #(
  parameter logic [7:0] OP_SET_PERMIT = nvr_pkg::OP_SET_PERMIT_DEF,
  parameter logic [7:0] OP_CLEAR_PERMIT = nvr_pkg::OP_CLEAR_PERMIT_DEF,
  parameter logic [7:0] OP_STATUS_READ = nvr_pkg::OP_STATUS_READ_DEF,
  parameter logic [7:0] OP_STATUS_WRITE = nvr_pkg::OP_STATUS_WRITE_DEF
) (
  input wire logic [7:0] opcode,
  output nvr_pkg::nvr_cmd_type cmd
);

  logic [7:0] op_base;

  // Strip the embedded address bit before matching the memory opcodes
  assign op_base = opcode & ~nvr_pkg::OP_ADDR_MSB_MASK;

  // Opcode to command flags
  always_comb begin
    cmd = '0;
    cmd.set_permit = (opcode == OP_SET_PERMIT);
    cmd.clear_permit = (opcode == OP_CLEAR_PERMIT);
    cmd.status_read = (opcode == OP_STATUS_READ);
    cmd.status_write = (opcode == OP_STATUS_WRITE);
    cmd.mem_write = (op_base == nvr_pkg::OP_WRITE_LOW);
    cmd.mem_read = (op_base == nvr_pkg::OP_READ_LOW);
    cmd.addr_msb = opcode[nvr_pkg::OP_ADDR_MSB_POS];
  end

endmodule : nvr_opdec

//--- verilog/nvr_sync.sv
`timescale 1ns/1ps

module nvr_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // Two-flop synchroniser plus one history stage
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      stage1 <= RST_VAL;
      stage2 <= RST_VAL;
      stage3 <= RST_VAL;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Edge pulses from settled stages only
  assign level = stage2;
  assign rise = stage2 & ~stage3;
  assign fall = ~stage2 & stage3;

endmodule : nvr_sync
